// ---- core/jtb_map.svh ----
// Constants for the test access port: instruction codes, widths, default id value.
// Assumes inclusion by the package and the design files; definitions only.
`ifndef JTB_MAP_SVH
`define JTB_MAP_SVH
`define JTB_IR_W        3
`define JTB_IR_EXTEST   3'h0
`define JTB_IR_IDCODE   3'h1
`define JTB_IR_SAMPLE   3'h2
`define JTB_IR_CLAMP    3'h3
`define JTB_IR_HIGHZ    3'h4
`define JTB_IR_BYPASS   3'h7
`define JTB_IR_CAPTURE  3'h1
`define JTB_ID_W        32
`define JTB_ID_DEFAULT  32'h12345679
`define JTB_BSR_W       8
`endif

// ---- core/jtb_pkg.sv ----
// Types for the test access port.
// Assumes jtb_map.svh is on the include path.
`include "jtb_map.svh"
package jtb_pkg;
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE  = 4'h1, ST_SELDR = 4'h2, ST_CAPDR = 4'h3,
    ST_SHDR  = 4'h4, ST_EX1DR = 4'h5, ST_PADR  = 4'h6, ST_EX2DR = 4'h7,
    ST_UPDR  = 4'h8, ST_SELIR = 4'h9, ST_CAPIR = 4'ha, ST_SHIR  = 4'hb,
    ST_EX1IR = 4'hc, ST_PAIR  = 4'hd, ST_EX2IR = 4'he, ST_UPIR  = 4'hf
  } jtb_state_e;
  typedef logic [`JTB_IR_W-1:0] jtb_instr_t;
endpackage

// ---- core/jtb_sync.sv ----
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/100ps
module jtb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1Reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1Reg <= '0;
      syncOut   <= '0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end
endmodule

// ---- core/jtb_tap.sv ----
// Test access port: state machine, instruction, bypass, id, boundary regs.
// Assumes test pins are asynchronous; test clock far slower than clk.
//
// Behaviour
// - Controller samples mode select and moves only on test clock rises or test reset
// - Power-up in reset state with id instruction; system logic untouched
// - Idle state holds instruction and all test registers
// - Select-DR goes capture on low, select-IR on high
// - Capture-DR loads selected register if supported; then shift or exit1
// - Shift-DR moves selected register one stage toward data-out per rise
// - Exit1-DR goes update on high, pause on low
// - Pause-DR holds; stays on low, exit2 on high
// - Exit2-DR goes update on high, back to shift on low
// - Update-DR falling edge latches shift path; then idle or select-DR
// - Select-IR goes capture-IR on low, reset on high
// - Capture-IR loads fixed value; then exit1-IR or shift-IR
// - Shift-IR shifts instruction stage only; high goes exit1-IR
// - Exit1, pause and exit2 IR transitions as for the DR branch
// - Update-IR falling edge makes shifted instruction current
// - Instruction register three bits, shift stage plus parallel latch
// - Code 010 samples pins into boundary register, preloads by shift
// - Code 000 drives outputs from boundary latches, captures inputs
// - Code 111 routes data through one-bit bypass
// - Code 001 selects 32-bit id register, captured then shifted, lsb 1
// - Code 100 floats all outputs, bypass in path
// - Code 011 drives outputs from boundary latches, bypass in path
`timescale 1ns/100ps
`include "jtb_map.svh"
module jtb_tap #(
  parameter logic [`JTB_ID_W-1:0] ID_CODE = `JTB_ID_DEFAULT // Arbitrary
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  test_clock_in,
  input  wire logic                  test_reset_n,
  input  wire logic                  test_data_in,
  input  wire logic                  test_mode_select,
  input  wire logic [`JTB_BSR_W-1:0] sysOut,
  input  wire logic [`JTB_BSR_W-1:0] pinIn,
  output logic                       test_data_out,
  output logic                       testDataOutOe,
  output logic      [`JTB_BSR_W-1:0] pinOut,
  output logic                       pinOutOe,
  output jtb_pkg::jtb_instr_t        instrCur
);
  import jtb_pkg::*;

  logic [3:0] pinSync;
  logic       tckReg;
  jtb_state_e stateReg;
  jtb_state_e stateNext;
  jtb_instr_t irShiftReg;
  logic       bypassReg;
  logic [`JTB_ID_W-1:0]  idReg;
  logic [`JTB_BSR_W-1:0] bsrShiftReg;
  logic [`JTB_BSR_W-1:0] bsrLatchReg;

  // The four test pins pass two flops before anything reads them
  jtb_sync #(.W(4)) uSync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({test_clock_in, test_reset_n, test_data_in,
               test_mode_select}),
    .syncOut (pinSync)
  );

  wire tck   = pinSync[3];
  wire trstN = pinSync[2];
  wire tdi   = pinSync[1];
  wire tms   = pinSync[0];
  wire rise  = tck & ~tckReg;
  wire fall  = ~tck & tckReg;

  // Register selection by current instruction
  wire selBsr = (instrCur == `JTB_IR_SAMPLE) ||
                (instrCur == `JTB_IR_EXTEST);
  wire selId  = (instrCur == `JTB_IR_IDCODE);
  wire selByp = ~selBsr & ~selId;
  wire drive  = (instrCur == `JTB_IR_EXTEST) ||
                (instrCur == `JTB_IR_CLAMP);
  wire shDr   = (stateReg == ST_SHDR);
  wire shIr   = (stateReg == ST_SHIR);
  wire capDr  = (stateReg == ST_CAPDR);
  wire drBit  = selBsr ? bsrShiftReg[0] :
                selId  ? idReg[0] : bypassReg;
  wire outBit = shIr ? irShiftReg[0] : drBit;
  wire [`JTB_BSR_W-1:0] pinOutNext = drive ? bsrLatchReg : sysOut;

  // Next state on each test clock rise
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_RESET: stateNext = tms ? ST_RESET : ST_IDLE;
      ST_IDLE:  stateNext = tms ? ST_SELDR : ST_IDLE;
      ST_SELDR: stateNext = tms ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: stateNext = tms ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  stateNext = tms ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: stateNext = tms ? ST_UPDR  : ST_PADR;
      ST_PADR:  stateNext = tms ? ST_EX2DR : ST_PADR;
      ST_EX2DR: stateNext = tms ? ST_UPDR  : ST_SHDR;
      ST_UPDR:  stateNext = tms ? ST_SELDR : ST_IDLE;
      ST_SELIR: stateNext = tms ? ST_RESET : ST_CAPIR;
      ST_CAPIR: stateNext = tms ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  stateNext = tms ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: stateNext = tms ? ST_UPIR  : ST_PAIR;
      ST_PAIR:  stateNext = tms ? ST_EX2IR : ST_PAIR;
      ST_EX2IR: stateNext = tms ? ST_UPIR  : ST_SHIR;
      ST_UPIR:  stateNext = tms ? ST_SELDR : ST_IDLE;
      default:  stateNext = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tckReg <= 1'b0;
    end else begin
      tckReg <= tck;
    end
  end

  // Test reset acts without a test clock edge
  always_ff @(posedge clk) begin
    if (rst || !trstN) begin
      stateReg <= ST_RESET;
    end else if (rise) begin
      stateReg <= stateNext;
    end
  end

  // Instruction shift stage
  always_ff @(posedge clk) begin
    if (rst) begin
      irShiftReg <= `JTB_IR_CAPTURE;
    end else if (rise && stateReg == ST_CAPIR) begin
      irShiftReg <= `JTB_IR_CAPTURE;
    end else if (rise && shIr) begin
      irShiftReg <= {tdi, irShiftReg[`JTB_IR_W-1:1]};
    end
  end

  // Current instruction; latched on the fall in Update-IR
  always_ff @(posedge clk) begin
    if (rst || !trstN || stateReg == ST_RESET) begin
      instrCur <= `JTB_IR_IDCODE;
    end else if (fall && stateReg == ST_UPIR) begin
      instrCur <= irShiftReg;
    end
  end

  // Data registers; unselected ones hold
  always_ff @(posedge clk) begin
    if (rst) begin
      bypassReg   <= 1'b0;
      idReg       <= ID_CODE;
      bsrShiftReg <= '0;
    end else if (rise && capDr) begin
      bypassReg <= selByp ? 1'b0 : bypassReg;
      idReg     <= selId ? ID_CODE : idReg;
      bsrShiftReg <= selBsr ? pinIn : bsrShiftReg;
    end else if (rise && shDr) begin
      bypassReg <= selByp ? tdi : bypassReg;
      idReg     <= selId ? {tdi, idReg[`JTB_ID_W-1:1]} : idReg;
      bsrShiftReg <= selBsr ?
        {tdi, bsrShiftReg[`JTB_BSR_W-1:1]} : bsrShiftReg;
    end
  end

  // Boundary latch updates on fall in Update-DR; held during clamp
  always_ff @(posedge clk) begin
    if (rst) begin
      bsrLatchReg <= '0;
    end else if (fall && stateReg == ST_UPDR && selBsr) begin
      bsrLatchReg <= bsrShiftReg;
    end
  end

  // Pins; data-out changes on the test clock fall like a real port, and on every clk while in the reset state
  always_ff @(posedge clk) begin
    if (rst) begin
      pinOut        <= '0;
      pinOutOe      <= 1'b1;
      test_data_out <= 1'b0;
      testDataOutOe <= 1'b0;
    end else begin
      pinOut   <= pinOutNext;
      pinOutOe <= (instrCur != `JTB_IR_HIGHZ);
      if (fall || stateReg == ST_RESET) begin
        test_data_out <= outBit;
        testDataOutOe <= shDr | shIr;
      end
    end
  end

  // Checks
  tms_reset_a: assert property (@(posedge clk) disable iff (rst)
    (rise && trstN && stateReg == ST_SELIR && tms) |=>
      stateReg == ST_RESET || !trstN)
    else $error("select-IR with high select did not reset");

  hold_state_a: assert property (@(posedge clk) disable iff (rst)
    (!rise && trstN) |=> $stable(stateReg))
    else $error("state moved without a test clock rise");

  reset_instr_a: assert property (@(posedge clk) disable iff (rst)
    stateReg == ST_RESET |=> instrCur == `JTB_IR_IDCODE)
    else $error("reset state lacks id instruction");

  idle_hold_a: assert property (@(posedge clk) disable iff (rst)
    stateReg == ST_IDLE |=> $stable(irShiftReg) && $stable(idReg)
      && $stable(bsrShiftReg))
    else $error("registers changed in idle");

  id_capture_a: assert property (@(posedge clk) disable iff (rst)
    (rise && capDr && selId) |=> idReg == ID_CODE && idReg[0])
    else $error("id not captured");

  instr_update_a: assert property (@(posedge clk) disable iff (rst)
    (fall && trstN && stateReg == ST_UPIR) |=>
      instrCur == $past(irShiftReg))
    else $error("instruction not latched on update");

  highz_pins_a: assert property (@(posedge clk) disable iff (rst)
    instrCur == `JTB_IR_HIGHZ |=> !pinOutOe)
    else $error("outputs driven under float instruction");

  tdo_float_a: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_IDLE) ##1 (stateReg == ST_IDLE) |-> !testDataOutOe)
    else $error("data-out driven outside shift");

  bypass_shift_a: assert property (@(posedge clk) disable iff (rst)
    (rise && shDr && selByp) |=> bypassReg == $past(tdi))
    else $error("bypass did not take data-in");
endmodule

// ---- verif/jtb_tester.sv ----
// Boundary-scan tester model: drives test clock, mode, data and reset pins.
// Assumes the caller starts each period just after a system clock edge.
`timescale 1ns/100ps
module jtb_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trstN,
  input  wire logic tdo,
  input  wire logic tdoOe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trstN = 1'b1;
  end
  // One 32 ns period; clock rests low between calls
  // Mode and data held 16 ns past the rise, above the 12 ns need
  task automatic cyc(input logic m, input logic dIn, output logic o,
                     output logic e);
    tms = m;
    tdi = dIn;
    #16 tck = 1'b1;
    #15 o = tdo;
    e = tdoOe;
    #1 tck = 1'b0;
    // Data line left as is; the next call sets it once, same time step
  endtask
  // Low for 40 ns, past the 8 ns the synchroniser needs
  task automatic pulseReset();
    trstN = 1'b0;
    #40 trstN = 1'b1;
  endtask
endmodule

// ---- verif/tb_jtag_tap_boundary_scan.sv ----
// Self-checking bench for the test access port, via the tester model.
// Assumes jtb_pkg, jtb_tap and jtb_tester are compiled before it.
`timescale 1ns/100ps
`include "jtb_map.svh"
module tb_jtag_tap_boundary_scan;
  import jtb_pkg::*;
  localparam logic [31:0] ID = 32'h2468ace1; // Arbitrary, lsb 1
  logic        clk, rst, tck, tms, tdi, trstN, tdo, tdoOe, pinOutOe, o, e;
  logic [7:0]  sysOut, pinIn, pinOut, pre, p;
  logic [31:0] d, r;
  jtb_instr_t  instrCur;
  jtb_instr_t  codes[3] = '{`JTB_IR_BYPASS, `JTB_IR_CLAMP, `JTB_IR_HIGHZ};
  int          n_errors = 0;
  int          n_checks = 0;
  logic [31:0] expQ[$], seenQ[$];
  string       nameQ[$];
  jtb_tap #(.ID_CODE(ID)) dut_u (
    .clk(clk), .rst(rst), .test_clock_in(tck), .test_reset_n(trstN),
    .test_data_in(tdi), .test_mode_select(tms), .sysOut(sysOut),
    .pinIn(pinIn), .test_data_out(tdo), .testDataOutOe(tdoOe),
    .pinOut(pinOut), .pinOutOe(pinOutOe), .instrCur(instrCur));
  jtb_tester tester_u (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
    .tdo(tdo), .tdoOe(tdoOe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] ex,
                       input logic [31:0] v);
    nameQ.push_back(nm);
    expQ.push_back(ex);
    seenQ.push_back(v);
  endtask
  initial begin
    forever begin
      wait (seenQ.size() > 0);
      n_checks++;
      if (seenQ[0] !== expQ[0]) begin
        n_errors++;
        $display("[ERR] %s expected %h seen %h", nameQ[0], expQ[0],
                 seenQ[0]);
      end
      seenQ.delete(0);
      expQ.delete(0);
      nameQ.delete(0);
    end
  end
  // Idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [31:0] din,
                      input bit pause, output logic [31:0] dout);
    dout = '0;
    tester_u.cyc(1'b1, 1'($urandom), o, e);
    if (ir) tester_u.cyc(1'b1, 1'($urandom), o, e);
    tester_u.cyc(1'b0, 1'($urandom), o, e);
    tester_u.cyc(1'b0, 1'($urandom), o, e);
    for (int i = 0; i < n; i++) begin
      tester_u.cyc(i == n - 1, din[i], o, e);
      dout[i] = o;
      check("tdo enable", 32'h1, e);
    end
    if (pause) begin
      tester_u.cyc(1'b0, 1'($urandom), o, e);
      tester_u.cyc(1'b0, 1'($urandom), o, e);
      tester_u.cyc(1'b1, 1'($urandom), o, e);
    end
    tester_u.cyc(1'b1, 1'($urandom), o, e);
    tester_u.cyc(1'b0, 1'($urandom), o, e);
    tester_u.cyc(1'b0, 1'($urandom), o, e);
    check("tdo enable idle", 32'h0, e);
  endtask
  task automatic loadIr(input jtb_instr_t c);
    scan(1'b1, 3, 32'(c), 1'b0, r);
    check("ir capture", `JTB_IR_CAPTURE, r[2:0]);
    check("instr", c, instrCur);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    void'($urandom(9826));
    rst = 1'b1;
    sysOut = 8'($urandom);
    pinIn = 8'h00;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    #1 check("instr reset", `JTB_IR_IDCODE, instrCur);
    check("pins normal", {sysOut, 1'b1}, {pinOut, pinOutOe});
    repeat (3) tester_u.cyc(1'b1, 1'($urandom), o, e);
    repeat (2) tester_u.cyc(1'b0, 1'($urandom), o, e);
    scan(1'b0, 32, $urandom, 1'b1, d);
    check("id code", ID, d);
    loadIr(`JTB_IR_SAMPLE);
    p = 8'($urandom);
    pinIn = p;
    pre = 8'($urandom);
    scan(1'b0, 8, 32'(pre), 1'b0, d);
    check("sample", p, d[7:0]);
    loadIr(`JTB_IR_EXTEST);
    check("extest out", pre, pinOut);
    pinIn = 8'($urandom);
    pre = 8'($urandom);
    scan(1'b0, 8, 32'(pre), 1'b1, d);
    check("extest in", pinIn, d[7:0]);
    check("extest upd", pre, pinOut);
    foreach (codes[k]) begin
      loadIr(codes[k]);
      sysOut = 8'($urandom);
      r = $urandom;
      scan(1'b0, 8, r, 1'b0, d);
      check("bypass", {r[6:0], 1'b0}, d[7:0]);
      check("out enable", codes[k] != `JTB_IR_HIGHZ, pinOutOe);
      if (codes[k] == `JTB_IR_CLAMP) check("clamp", pre, pinOut);
    end
    repeat (3) tester_u.cyc(1'b1, 1'($urandom), o, e);
    tester_u.cyc(1'b0, 1'($urandom), o, e);
    check("instr selir", `JTB_IR_IDCODE, instrCur);
    loadIr(`JTB_IR_BYPASS);
    tester_u.pulseReset();
    #40 check("instr trst", `JTB_IR_IDCODE, instrCur);
    #20 close_out();
  end
endmodule
